// ### common/capture_mix_regs.vh
/*
 * register offsets, field positions and reset values for the capture and
 * playback mixer control bank.
 * assumes an 8-bit data path addressed by 16-bit subaddresses.
 */
`ifndef CAPTURE_MIX_REGS_VH
`define CAPTURE_MIX_REGS_VH

// ----------------------------------------------------------------------
// register subaddresses
// ----------------------------------------------------------------------
`define RECORD_CONV_CONFIG_ADDR     16'h4019
`define LEFT_CAPTURE_VOLUME_ADDR    16'h401A
`define RIGHT_CAPTURE_VOLUME_ADDR   16'h401B
`define LEFT_PLAY_MIX_CONTROL_ADDR  16'h401C
`define LEFT_PLAY_MIX_BYPASS_ADDR   16'h401D
`define RIGHT_PLAY_MIX_CONTROL_ADDR 16'h401E
`define RIGHT_PLAY_MIX_BYPASS_ADDR  16'h401F
`define LEFT_LINE_SUM_MIX_ADDR      16'h4020
`define RIGHT_LINE_SUM_MIX_ADDR     16'h4021
`define MONO_SUM_MIX_ADDR           16'h4022

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RECORD_CONV_CONFIG_RST      8'h10
`define ZERO_RST                    8'h00

// ----------------------------------------------------------------------
// writable bit masks, reserved bits cleared
// ----------------------------------------------------------------------
`define RECORD_CONV_CONFIG_MASK     8'h7F
`define PLAY_MIX_CONTROL_MASK       8'h7F
`define FULL_MASK                   8'hFF
`define LINE_SUM_MIX_MASK           8'h1F
`define MONO_SUM_MIX_MASK           8'h07

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define POLARITY_BIT                6
`define HIGHPASS_BIT                5
`define MIC_POL_BIT                 4
`define MIC_SWAP_BIT                3
`define INPUT_SEL_BIT               2
`define RIGHT_DAC_BIT               6
`define LEFT_DAC_BIT                5
`define ENABLE_BIT                  0

// ----------------------------------------------------------------------
// slewing step period in core clocks
// ----------------------------------------------------------------------
`define SLEW_STEP_CYCLES            16

`endif

// ### hdl/masked_reg.v
/*
 * one 8-bit control register with a writable-bit mask.
 * assumes a one-cycle write strobe on the core clock.
 */
`timescale 1ns/1ns
module masked_reg #(
   parameter [7:0] RESET_VALUE = 8'h00, // power-on value
   parameter [7:0] WRITE_MASK  = 8'hFF  // bits that hold data
) (
   input  wire       clock,
   input  wire       rst,
   input  wire       write_en,
   input  wire [7:0] write_data,
   output reg  [7:0] value_r
);

   // ----------------------------------------------------------------------
   // storage; masked bits stay zero forever
   // ----------------------------------------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         value_r <= RESET_VALUE & WRITE_MASK;
      end else if (write_en) begin
         value_r <= write_data & WRITE_MASK;
      end
   end

endmodule

// ### hdl/volume_slew.v
/*
 * moves a live attenuation code one step at a time toward its target.
 * assumes the target comes from a register on the same clock.
 */
`timescale 1ns/1ns
`include "capture_mix_regs.vh"
module volume_slew #(
   parameter       WIDTH       = 8,                 // code width
   parameter [7:0] STEP_CYCLES = `SLEW_STEP_CYCLES  // clocks per step
) (
   input  wire             clock,
   input  wire             rst,
   input  wire [WIDTH-1:0] target,
   output reg  [WIDTH-1:0] level_r
);

   reg [7:0] tick_r;     // step pacing counter

   // ----------------------------------------------------------------------
   // pacing counter and single-step move
   // ----------------------------------------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         tick_r  <= 8'h00;
         level_r <= {WIDTH{1'b0}};
      end else if (tick_r == STEP_CYCLES - 8'h01) begin
         tick_r <= 8'h00;
         // steps avoid zipper noise from a sudden jump
         if (level_r < target) begin
            level_r <= level_r + {{(WIDTH-1){1'b0}}, 1'b1};
         end else if (level_r > target) begin
            level_r <= level_r - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end else begin
         tick_r <= tick_r + 8'h01;
      end
   end

endmodule

// ### hdl/codec_capture_mix_ctrl_regs.v
/*
 * control register bank for the record converter path and the playback
 * line and mono mixers, with decoded control outputs for the analog side.
 * assumes the serial control port delivers decoded write and read strobes
 * with a 16-bit subaddress and 8-bit data on the core clock.
 */
// Functional notes
// RULE1: bit 6 inverts record converter polarity
// RULE2: bit 5 turns record high-pass on
// RULE3: bit 4 zero inverts microphone data
// RULE4: bit 3 swaps microphone left and right
// RULE5: converter enable field selects channels
// RULE6: left capture volume 0.375 dB steps
// RULE7: right capture volume, slewed between settings
// RULE8: left mixer dac unmute bits 6, 5
// RULE9: left mixer aux gain code, mute default
// RULE10: bit 0 enables left playback mixer
// RULE11: left mixer bypass gains, two nibbles
// RULE12: right mixer dac unmute bits 6, 5
// RULE13: right mixer aux gain and enable
// RULE14: right mixer bypass gains, mute default
// RULE15: left line mixer two boost fields
// RULE16: right line mixer same layout
// RULE17: boost 01 is 0 dB, 10 is 6 dB
// RULE18: mono field selects common-mode or sums
// RULE19: reserved bits read zero, ignore writes
// RULE20: software avoids reserved boost codes
`timescale 1ns/1ns
`include "capture_mix_regs.vh"
module codec_capture_mix_ctrl_regs (
   input  wire        clock,
   input  wire        rst,
   input  wire        write_en,
   input  wire        read_en,
   input  wire [15:0] address,
   input  wire [7:0]  write_data,
   output reg  [7:0]  read_data_r,
   output reg         read_hit_r,
   output reg         record_polarity_invert,
   output reg         record_highpass_sel,
   output reg         mic_data_invert,
   output reg         mic_channel_swap,
   output reg         record_input_select,
   output reg         left_conv_on,
   output reg         right_conv_on,
   output reg  [7:0]  left_capture_atten,
   output reg  [7:0]  right_capture_atten,
   output reg         lmix_right_dac_on,
   output reg         lmix_left_dac_on,
   output reg  [3:0]  lmix_aux_gain,
   output reg         lmix_enable,
   output reg  [3:0]  lmix_right_bypass_gain,
   output reg  [3:0]  lmix_left_bypass_gain,
   output reg         rmix_right_dac_on,
   output reg         rmix_left_dac_on,
   output reg  [3:0]  rmix_aux_gain,
   output reg         rmix_enable,
   output reg  [3:0]  rmix_right_bypass_gain,
   output reg  [3:0]  rmix_left_bypass_gain,
   output reg  [1:0]  lline_from_rmix_boost,
   output reg  [1:0]  lline_from_lmix_boost,
   output reg         lline_mix_enable,
   output reg  [1:0]  rline_from_rmix_boost,
   output reg  [1:0]  rline_from_lmix_boost,
   output reg         rline_mix_enable,
   output reg  [1:0]  mono_mix_mode,
   output reg         mono_mix_enable
);

   // ----------------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------------
   wire sel_rcc = (address == `RECORD_CONV_CONFIG_ADDR);     // converter setup
   wire sel_lcv = (address == `LEFT_CAPTURE_VOLUME_ADDR);    // left volume
   wire sel_rcv = (address == `RIGHT_CAPTURE_VOLUME_ADDR);   // right volume
   wire sel_lmc = (address == `LEFT_PLAY_MIX_CONTROL_ADDR);  // left mixer
   wire sel_lmb = (address == `LEFT_PLAY_MIX_BYPASS_ADDR);   // left bypass
   wire sel_rmc = (address == `RIGHT_PLAY_MIX_CONTROL_ADDR); // right mixer
   wire sel_rmb = (address == `RIGHT_PLAY_MIX_BYPASS_ADDR);  // right bypass
   wire sel_lls = (address == `LEFT_LINE_SUM_MIX_ADDR);      // left line sum
   wire sel_rls = (address == `RIGHT_LINE_SUM_MIX_ADDR);     // right line sum
   wire sel_mon = (address == `MONO_SUM_MIX_ADDR);           // mono sum

   wire [7:0] rcc_q;     // stored register values
   wire [7:0] lcv_q;
   wire [7:0] rcv_q;
   wire [7:0] lmc_q;
   wire [7:0] lmb_q;
   wire [7:0] rmc_q;
   wire [7:0] rmb_q;
   wire [7:0] lls_q;
   wire [7:0] rls_q;
   wire [7:0] mon_q;
   wire [7:0] left_level;   // slewed volume levels
   wire [7:0] right_level;

   // ----------------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------------
   // RULE19: reserved bits masked
   // RULE3: microphone default normal
   masked_reg #(.RESET_VALUE(`RECORD_CONV_CONFIG_RST),
                .WRITE_MASK(`RECORD_CONV_CONFIG_MASK)) u_rcc (
      .clock(clock),
      .rst(rst),
      .write_en(write_en & sel_rcc),
      .write_data(write_data),
      .value_r(rcc_q));
   masked_reg #(.RESET_VALUE(`ZERO_RST), .WRITE_MASK(`FULL_MASK)) u_lcv (
      .clock(clock),
      .rst(rst),
      .write_en(write_en & sel_lcv),
      .write_data(write_data),
      .value_r(lcv_q));
   masked_reg #(.RESET_VALUE(`ZERO_RST), .WRITE_MASK(`FULL_MASK)) u_rcv (
      .clock(clock),
      .rst(rst),
      .write_en(write_en & sel_rcv),
      .write_data(write_data),
      .value_r(rcv_q));
   masked_reg #(.RESET_VALUE(`ZERO_RST),
                .WRITE_MASK(`PLAY_MIX_CONTROL_MASK)) u_lmc (
      .clock(clock),
      .rst(rst),
      .write_en(write_en & sel_lmc),
      .write_data(write_data),
      .value_r(lmc_q));
   masked_reg #(.RESET_VALUE(`ZERO_RST), .WRITE_MASK(`FULL_MASK)) u_lmb (
      .clock(clock),
      .rst(rst),
      .write_en(write_en & sel_lmb),
      .write_data(write_data),
      .value_r(lmb_q));
   masked_reg #(.RESET_VALUE(`ZERO_RST),
                .WRITE_MASK(`PLAY_MIX_CONTROL_MASK)) u_rmc (
      .clock(clock),
      .rst(rst),
      .write_en(write_en & sel_rmc),
      .write_data(write_data),
      .value_r(rmc_q));
   masked_reg #(.RESET_VALUE(`ZERO_RST), .WRITE_MASK(`FULL_MASK)) u_rmb (
      .clock(clock),
      .rst(rst),
      .write_en(write_en & sel_rmb),
      .write_data(write_data),
      .value_r(rmb_q));
   masked_reg #(.RESET_VALUE(`ZERO_RST),
                .WRITE_MASK(`LINE_SUM_MIX_MASK)) u_lls (
      .clock(clock),
      .rst(rst),
      .write_en(write_en & sel_lls),
      .write_data(write_data),
      .value_r(lls_q));
   masked_reg #(.RESET_VALUE(`ZERO_RST),
                .WRITE_MASK(`LINE_SUM_MIX_MASK)) u_rls (
      .clock(clock),
      .rst(rst),
      .write_en(write_en & sel_rls),
      .write_data(write_data),
      .value_r(rls_q));
   masked_reg #(.RESET_VALUE(`ZERO_RST),
                .WRITE_MASK(`MONO_SUM_MIX_MASK)) u_mon (
      .clock(clock),
      .rst(rst),
      .write_en(write_en & sel_mon),
      .write_data(write_data),
      .value_r(mon_q));

   // ----------------------------------------------------------------------
   // capture volume slewing
   // ----------------------------------------------------------------------
   // RULE6: left attenuation slew
   volume_slew #(.WIDTH(8)) u_left_slew (
      .clock(clock),
      .rst(rst),
      .target(lcv_q),
      .level_r(left_level));
   // RULE7: right attenuation slew
   volume_slew #(.WIDTH(8)) u_right_slew (
      .clock(clock),
      .rst(rst),
      .target(rcv_q),
      .level_r(right_level));

   // ----------------------------------------------------------------------
   // read path; unmapped subaddresses read zero, no hit
   // ----------------------------------------------------------------------
   reg [7:0] read_nxt;   // selected readback byte
   reg       hit_nxt;    // address belongs to this bank

   always @* begin
      read_nxt = 8'h00;
      hit_nxt  = 1'b1;
      // RULE19: masked readback
      case (address)
         `RECORD_CONV_CONFIG_ADDR:     read_nxt = rcc_q;
         `LEFT_CAPTURE_VOLUME_ADDR:    read_nxt = lcv_q;
         `RIGHT_CAPTURE_VOLUME_ADDR:   read_nxt = rcv_q;
         `LEFT_PLAY_MIX_CONTROL_ADDR:  read_nxt = lmc_q;
         `LEFT_PLAY_MIX_BYPASS_ADDR:   read_nxt = lmb_q;
         `RIGHT_PLAY_MIX_CONTROL_ADDR: read_nxt = rmc_q;
         `RIGHT_PLAY_MIX_BYPASS_ADDR:  read_nxt = rmb_q;
         `LEFT_LINE_SUM_MIX_ADDR:      read_nxt = lls_q;
         `RIGHT_LINE_SUM_MIX_ADDR:     read_nxt = rls_q;
         `MONO_SUM_MIX_ADDR:           read_nxt = mon_q;
         default:                      hit_nxt  = 1'b0;
      endcase
   end

   // read data registered one cycle after the strobe
   always @(posedge clock) begin
      if (rst) begin
         read_data_r <= 8'h00;
         read_hit_r  <= 1'b0;
      end else if (read_en) begin
         read_data_r <= read_nxt;
         read_hit_r  <= hit_nxt;
      end else begin
         read_hit_r  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // decoded controls, one register stage so outputs come from flops
   // ----------------------------------------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         record_polarity_invert <= 1'b0;
         record_highpass_sel    <= 1'b0;
         mic_data_invert        <= 1'b0;
         mic_channel_swap       <= 1'b0;
         record_input_select    <= 1'b0;
         left_conv_on           <= 1'b0;
         right_conv_on          <= 1'b0;
         left_capture_atten     <= 8'h00;
         right_capture_atten    <= 8'h00;
         lmix_right_dac_on      <= 1'b0;
         lmix_left_dac_on       <= 1'b0;
         lmix_aux_gain          <= 4'h0;
         lmix_enable            <= 1'b0;
         lmix_right_bypass_gain <= 4'h0;
         lmix_left_bypass_gain  <= 4'h0;
         rmix_right_dac_on      <= 1'b0;
         rmix_left_dac_on       <= 1'b0;
         rmix_aux_gain          <= 4'h0;
         rmix_enable            <= 1'b0;
         rmix_right_bypass_gain <= 4'h0;
         rmix_left_bypass_gain  <= 4'h0;
         lline_from_rmix_boost  <= 2'h0;
         lline_from_lmix_boost  <= 2'h0;
         lline_mix_enable       <= 1'b0;
         rline_from_rmix_boost  <= 2'h0;
         rline_from_lmix_boost  <= 2'h0;
         rline_mix_enable       <= 1'b0;
         mono_mix_mode          <= 2'h0;
         mono_mix_enable        <= 1'b0;
      end else begin
         // RULE1: polarity invert
         record_polarity_invert <= rcc_q[`POLARITY_BIT];
         // RULE2: high-pass select
         record_highpass_sel    <= rcc_q[`HIGHPASS_BIT];
         // RULE3: zero means inverted
         mic_data_invert        <= ~rcc_q[`MIC_POL_BIT];
         // RULE4: channel swap
         mic_channel_swap       <= rcc_q[`MIC_SWAP_BIT];
         record_input_select    <= rcc_q[`INPUT_SEL_BIT];
         // RULE5: enable field decode
         left_conv_on           <= rcc_q[0];
         right_conv_on          <= rcc_q[1];
         // RULE6: slewed left code
         left_capture_atten     <= left_level;
         // RULE7: slewed right code
         right_capture_atten    <= right_level;
         // RULE8: left mixer dac unmutes
         lmix_right_dac_on      <= lmc_q[`RIGHT_DAC_BIT];
         lmix_left_dac_on       <= lmc_q[`LEFT_DAC_BIT];
         // RULE9: aux gain code passed whole
         lmix_aux_gain          <= lmc_q[4:1];
         // RULE10: left mixer enable
         lmix_enable            <= lmc_q[`ENABLE_BIT];
         // RULE11: left bypass nibbles
         lmix_right_bypass_gain <= lmb_q[7:4];
         lmix_left_bypass_gain  <= lmb_q[3:0];
         // RULE12: right mixer dac unmutes
         rmix_right_dac_on      <= rmc_q[`RIGHT_DAC_BIT];
         rmix_left_dac_on       <= rmc_q[`LEFT_DAC_BIT];
         // RULE13: right aux gain and enable
         rmix_aux_gain          <= rmc_q[4:1];
         rmix_enable            <= rmc_q[`ENABLE_BIT];
         // RULE14: right bypass nibbles
         rmix_right_bypass_gain <= rmb_q[7:4];
         rmix_left_bypass_gain  <= rmb_q[3:0];
         // RULE15: left line boosts
         // RULE17: codes drive analog gain as is
         lline_from_rmix_boost  <= lls_q[4:3];
         lline_from_lmix_boost  <= lls_q[2:1];
         lline_mix_enable       <= lls_q[`ENABLE_BIT];
         // RULE16: right line boosts
         rline_from_rmix_boost  <= rls_q[4:3];
         rline_from_lmix_boost  <= rls_q[2:1];
         rline_mix_enable       <= rls_q[`ENABLE_BIT];
         // RULE18: mono mode field
         mono_mix_mode          <= mon_q[2:1];
         mono_mix_enable        <= mon_q[`ENABLE_BIT];
      end
   end

endmodule

// ### test/codec_capture_mix_ctrl_regs_sva.sv
/*
 * timing checks for the capture and mixer control bank, bound to its top.
 * assumes one core clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns
module capture_mix_sva (
   input wire        clock,
   input wire        rst,
   input wire        write_en,
   input wire        read_en,
   input wire [15:0] address,
   input wire [7:0]  write_data,
   input wire [7:0]  read_data_r,
   input wire        read_hit_r,
   input wire        record_polarity_invert,
   input wire        mic_data_invert,
   input wire        left_conv_on,
   input wire        right_conv_on,
   input wire [3:0]  lmix_aux_gain,
   input wire        lmix_enable,
   input wire [1:0]  lline_from_rmix_boost,
   input wire [1:0]  mono_mix_mode,
   input wire [7:0]  right_capture_atten
);
   // ------------------------------------------------------------
   // write decodes, a lone write is followed by an idle cycle
   // ------------------------------------------------------------
   wire w_rec  = write_en && address == 16'h4019;   // converter config write
   wire w_lmix = write_en && address == 16'h401C;   // left mixer write
   wire w_line = write_en && address == 16'h4020;   // left line mixer write
   wire w_mono = write_en && address == 16'h4022;   // mono mixer write
   wire unmap  = address < 16'h4019 || address > 16'h4022; // outside bank
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_pol; w_rec ##1 !w_rec |=> record_polarity_invert == $past(write_data[6], 2);
   endproperty
   a_pol: assert property (p_pol) else $error("polarity bit not followed");
   property p_mic; w_rec ##1 !w_rec |=> mic_data_invert == !$past(write_data[4], 2);
   endproperty
   a_mic: assert property (p_mic) else $error("mic polarity sense wrong");
   property p_conv; w_rec ##1 !w_rec |=>
      {right_conv_on, left_conv_on} == $past(write_data[1:0], 2); endproperty
   a_conv: assert property (p_conv) else $error("converter enables wrong");
   property p_aux; w_lmix ##1 !w_lmix |=>
      {lmix_aux_gain, lmix_enable} == $past(write_data[4:0], 2); endproperty
   a_aux: assert property (p_aux) else $error("left mixer gain wrong");
   property p_boost; w_line ##1 !w_line |=> lline_from_rmix_boost == $past(write_data[4:3], 2);
   endproperty
   a_boost: assert property (p_boost) else $error("line boost wrong");
   property p_mono; w_mono ##1 !w_mono |=> mono_mix_mode == $past(write_data[2:1], 2);
   endproperty
   a_mono: assert property (p_mono) else $error("mono mode wrong");
   property p_unmap; read_en && unmap |=> !read_hit_r && read_data_r == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read answered");
   property p_rsv; read_en && address == 16'h4019 |=> read_hit_r && !read_data_r[7];
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit read as one");
   property p_slew; !$stable(right_capture_atten) |->
      (right_capture_atten - $past(right_capture_atten)) inside {8'h01, 8'hFF}; endproperty
   a_slew: assert property (p_slew) else $error("volume jumped");
endmodule
bind codec_capture_mix_ctrl_regs capture_mix_sva chk (.clock(clock), .rst(rst),
   .write_en(write_en), .read_en(read_en), .address(address), .write_data(write_data),
   .read_data_r(read_data_r), .read_hit_r(read_hit_r),
   .record_polarity_invert(record_polarity_invert), .mic_data_invert(mic_data_invert),
   .left_conv_on(left_conv_on), .right_conv_on(right_conv_on),
   .lmix_aux_gain(lmix_aux_gain), .lmix_enable(lmix_enable),
   .lline_from_rmix_boost(lline_from_rmix_boost), .mono_mix_mode(mono_mix_mode),
   .right_capture_atten(right_capture_atten));

// ### test/codec_capture_mix_ctrl_regs_test.sv
/*
 * self-checking bench for the capture and mixer control bank.
 * assumes decoded one-cycle strobes, registered read data, 50 ns clock.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
   $display("FAIL %0t mismatch got %h want %h", $time, (g), (e)); end end
module codec_capture_mix_ctrl_regs_test;
   // ------------------------------------------------------------
   // stimulus and observed outputs
   // ------------------------------------------------------------
   reg         clock = 1'b0, rst = 1'b1, write_en = 1'b0, read_en = 1'b0;
   reg  [15:0] address = 16'h0000;       // subaddress driven to the bank
   reg  [7:0]  write_data = 8'h00;       // write byte
   wire [7:0]  read_data_r, left_capture_atten, right_capture_atten;
   wire        read_hit_r, record_polarity_invert, record_highpass_sel, mic_data_invert;
   wire        mic_channel_swap, record_input_select, left_conv_on, right_conv_on;
   wire        lmix_right_dac_on, lmix_left_dac_on, lmix_enable;
   wire        rmix_right_dac_on, rmix_left_dac_on, rmix_enable;
   wire [3:0]  lmix_aux_gain, lmix_right_bypass_gain, lmix_left_bypass_gain;
   wire [3:0]  rmix_aux_gain, rmix_right_bypass_gain, rmix_left_bypass_gain;
   wire [1:0]  lline_from_rmix_boost, lline_from_lmix_boost, rline_from_rmix_boost;
   wire [1:0]  rline_from_lmix_boost, mono_mix_mode;
   wire        lline_mix_enable, rline_mix_enable, mono_mix_enable;
   int         fail_count = 0, checks = 0, cycles = 0; // tallies and watchdog
   reg  [7:0]  d;                        // read scratch
   reg         h;                        // hit scratch
   codec_capture_mix_ctrl_regs uut (.clock(clock), .rst(rst), .write_en(write_en),
      .read_en(read_en), .address(address), .write_data(write_data),
      .read_data_r(read_data_r), .read_hit_r(read_hit_r),
      .record_polarity_invert(record_polarity_invert),
      .record_highpass_sel(record_highpass_sel), .mic_data_invert(mic_data_invert),
      .mic_channel_swap(mic_channel_swap), .record_input_select(record_input_select),
      .left_conv_on(left_conv_on), .right_conv_on(right_conv_on),
      .left_capture_atten(left_capture_atten), .right_capture_atten(right_capture_atten),
      .lmix_right_dac_on(lmix_right_dac_on), .lmix_left_dac_on(lmix_left_dac_on),
      .lmix_aux_gain(lmix_aux_gain), .lmix_enable(lmix_enable),
      .lmix_right_bypass_gain(lmix_right_bypass_gain),
      .lmix_left_bypass_gain(lmix_left_bypass_gain),
      .rmix_right_dac_on(rmix_right_dac_on), .rmix_left_dac_on(rmix_left_dac_on),
      .rmix_aux_gain(rmix_aux_gain), .rmix_enable(rmix_enable),
      .rmix_right_bypass_gain(rmix_right_bypass_gain),
      .rmix_left_bypass_gain(rmix_left_bypass_gain),
      .lline_from_rmix_boost(lline_from_rmix_boost),
      .lline_from_lmix_boost(lline_from_lmix_boost), .lline_mix_enable(lline_mix_enable),
      .rline_from_rmix_boost(rline_from_rmix_boost),
      .rline_from_lmix_boost(rline_from_lmix_boost), .rline_mix_enable(rline_mix_enable),
      .mono_mix_mode(mono_mix_mode), .mono_mix_enable(mono_mix_enable));
   // free-running core clock, 50 ns period
   always #25 clock = ~clock;
   // watchdog: the whole run needs well under 4000 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         fail_count++;
         $display("FAIL %0t watchdog expired", $time);
         finish_test;
      end
   end
   // ------------------------------------------------------------
   // bus cycles
   // ------------------------------------------------------------
   task wr(input [15:0] a, input [7:0] v);
      @(posedge clock);
      write_en <= 1'b1; address <= a; write_data <= v;
      @(posedge clock);
      write_en <= 1'b0;
   endtask
   // control outputs change one cycle after the taken edge
   task settle;
      repeat (2) @(posedge clock);
      #1;
   endtask
   task rd(input [15:0] a);
      @(posedge clock);
      read_en <= 1'b1; address <= a;
      @(posedge clock);
      read_en <= 1'b0;
      #1;
      d = read_data_r;
      h = read_hit_r;
   endtask
   task rchk(input [15:0] a, input [7:0] e);
      rd(a);
      `CHK(d, e)
      `CHK(h, 1'b1)
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_reset;
      for (int i = 0; i < 10; i++) rchk(16'h4019 + i, (i == 0) ? 8'h10 : 8'h00);
      `CHK(mic_data_invert, 1'b0)
      `CHK({lmix_aux_gain, rmix_left_bypass_gain, lmix_enable}, 9'h000)
      `CHK({mono_mix_mode, lline_from_lmix_boost}, 4'h0)
      $display("test reset done");
   endtask
   task t_record;
      wr(16'h4019, 8'hFF);
      settle;
      `CHK(record_polarity_invert, 1'b1)
      `CHK(record_highpass_sel, 1'b1)
      `CHK(mic_data_invert, 1'b0)
      `CHK({mic_channel_swap, record_input_select}, 2'b11)
      rchk(16'h4019, 8'h7F);
      for (int i = 0; i < 4; i++) begin
         wr(16'h4019, i[7:0]);
         settle;
         `CHK({right_conv_on, left_conv_on}, i[1:0])
      end
      `CHK({mic_data_invert, record_polarity_invert, mic_channel_swap}, 3'b100)
      $display("test record done");
   endtask
   task t_mixers;
      wr(16'h401C, 8'hFF);
      rchk(16'h401C, 8'h7F);
      for (int k = 0; k < 9; k++) begin
         wr(16'h401C, {3'b010, k[3:0], 1'b1});
         wr(16'h401E, {3'b001, k[3:0], 1'b0});
         settle;
         `CHK({lmix_aux_gain, lmix_enable}, {k[3:0], 1'b1})
         `CHK({lmix_right_dac_on, lmix_left_dac_on}, 2'b10)
         `CHK({rmix_right_dac_on, rmix_left_dac_on}, 2'b01)
         `CHK({rmix_aux_gain, rmix_enable}, {k[3:0], 1'b0})
      end
      wr(16'h401D, 8'h81);
      wr(16'h401F, 8'h18);
      settle;
      `CHK({lmix_right_bypass_gain, lmix_left_bypass_gain}, 8'h81)
      `CHK({rmix_right_bypass_gain, rmix_left_bypass_gain}, 8'h18)
      $display("test mixers done");
   endtask
   task t_line;
      for (int k = 0; k < 3; k++) begin
         wr(16'h4020, {3'b000, k[1:0], 2'd2 - k[1:0], 1'b1});
         wr(16'h4021, {3'b111, 2'd2 - k[1:0], k[1:0], 1'b0});
         settle;
         `CHK({lline_from_rmix_boost, lline_mix_enable}, {k[1:0], 1'b1})
         `CHK(lline_from_lmix_boost, 2'd2 - k[1:0])
         `CHK({rline_from_rmix_boost, rline_from_lmix_boost}, {2'd2 - k[1:0], k[1:0]})
         `CHK(rline_mix_enable, 1'b0)
      end
      rchk(16'h4021, 8'h04);
      for (int k = 0; k < 3; k++) begin
         wr(16'h4022, {5'b11111, k[1:0], 1'b1});
         settle;
         `CHK({mono_mix_mode, mono_mix_enable}, {k[1:0], 1'b1})
      end
      rchk(16'h4022, 8'h05);
      $display("test line done");
   endtask
   task t_unmapped;
      wr(16'h4018, 8'hFF);
      wr(16'h4023, 8'hFF);
      rd(16'h4018);
      `CHK({h, d}, 9'h000)
      rd(16'h4023);
      `CHK({h, d}, 9'h000)
      rchk(16'h4019, 8'h03);
      $display("test unmapped done");
   endtask
   task t_volume;
      wr(16'h401A, 8'h05);
      wr(16'h401B, 8'h03);
      settle;
      `CHK(left_capture_atten < 8'h05, 1'b1)
      // slewing takes up to 16 clocks per step plus an output cycle
      for (int n = 0; n < 120 && left_capture_atten !== 8'h05; n++) @(posedge clock);
      #1;
      `CHK(left_capture_atten, 8'h05)
      `CHK(right_capture_atten, 8'h03)
      wr(16'h401B, 8'h00);
      for (int n = 0; n < 80 && right_capture_atten !== 8'h00; n++) @(posedge clock);
      #1;
      `CHK(right_capture_atten, 8'h00)
      rchk(16'h401A, 8'h05);
      $display("test volume done");
   endtask
   task finish_test;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // main sequence: 4 reset cycles, then the scenarios
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      t_reset;
      t_record;
      t_mixers;
      t_line;
      t_unmapped;
      t_volume;
      finish_test;
   end
endmodule
